// *** core/swt_top.sv ***
`timescale 1ns/10ps
`default_nettype none
module swt_top (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic xosc32_clk_i,
  input wire logic rcosc_clk_i,
  input wire logic use_rc_osc_i,
  input wire logic [1:0] power_mode_i,
  input wire logic xosc_running_i,
  input wire logic [7:0] sfr_addr_i,
  input wire logic sfr_wr_i,
  input wire logic [7:0] sfr_wdata_i,
  input wire logic sfr_rd_i,
  output logic [7:0] sfr_rdata_o,
  output logic first_event_o,
  output logic second_event_o,
  output logic vreg_on_o,
  output logic xosc_start_o,
  output logic sleep_timer_irq_o,
  output logic [5:0] rc_trim_o
);

  // ****************************************
  // low-frequency tick
  // ****************************************
  swt_lf_if lf ();
  swt_pkg::swt_pmode_t pmode;
  logic pm_sleep;

  assign pmode = swt_pkg::swt_pmode_t'(power_mode_i);
  assign pm_sleep = (pmode == swt_pkg::SWT_PM_LIGHT) || (pmode == swt_pkg::SWT_PM_DEEP);
  assign lf.use_rc = use_rc_osc_i;
  // counter stops only in oscillators-off mode
  assign lf.run = (pmode != swt_pkg::SWT_PM_OFF);

  swt_lf_tick u_tick (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .xosc32_clk_i(xosc32_clk_i),
    .rcosc_clk_i(rcosc_clk_i),
    .lf(lf)
  );

  // ****************************************
  // register decode
  // ****************************************
  logic wr_ctl;
  logic wr_irq;
  logic wr_lo;
  logic wr_hi;

  assign wr_ctl = sfr_wr_i && (sfr_addr_i == swt_pkg::SWT_ADDR_CTL);
  assign wr_irq = sfr_wr_i && (sfr_addr_i == swt_pkg::SWT_ADDR_IRQ);
  assign wr_lo = sfr_wr_i && (sfr_addr_i == swt_pkg::SWT_ADDR_PER_LO);
  assign wr_hi = sfr_wr_i && (sfr_addr_i == swt_pkg::SWT_ADDR_PER_HI);

  // ****************************************
  // control and period registers
  // ****************************************
  logic [2:0] delay_code;
  logic [1:0] count_resolution_sel;
  logic [15:0] wake_period_mantissa;

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      delay_code <= swt_pkg::SWT_RST_DELAY;
      count_resolution_sel <= swt_pkg::SWT_RST_RES;
    end else if (wr_ctl) begin
      delay_code <= sfr_wdata_i[swt_pkg::SWT_CTL_DELAY_LSB +: 3];
      count_resolution_sel <= sfr_wdata_i[1:0];
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      wake_period_mantissa <= {swt_pkg::SWT_RST_PER_HI, swt_pkg::SWT_RST_PER_LO};
    end else begin
      if (wr_lo) begin
        wake_period_mantissa[7:0] <= sfr_wdata_i;
      end
      if (wr_hi) begin
        wake_period_mantissa[15:8] <= sfr_wdata_i;
      end
    end
  end

  // ****************************************
  // sleep counter and window
  // ****************************************
  logic [swt_pkg::SWT_CNT_W-1:0] sleep_cnt;
  logic [swt_pkg::SWT_CNT_W-1:0] next_cnt;
  logic [15:0] window;
  logic [15:0] next_window;
  logic first_hit;
  logic sw_reset;

  // only a written one clears; the bit itself is never stored
  assign sw_reset = wr_ctl && sfr_wdata_i[swt_pkg::SWT_CTL_RESET_BIT];

  // window pick is a pure shift of the live count
  function automatic logic [15:0] pick_window(input logic [swt_pkg::SWT_CNT_W-1:0] c,
                                              input logic [1:0] res);
    logic [swt_pkg::SWT_CNT_W-1:0] s;
    s = c >> (swt_pkg::SWT_RES_SHIFT * int'(res));
    return s[15:0];
  endfunction

  // window select; counter itself untouched by it
  assign window = pick_window(sleep_cnt, count_resolution_sel);
  assign next_cnt = sleep_cnt + 31'h0000_0001;
  assign next_window = pick_window(next_cnt, count_resolution_sel);
  // match on the count about to be reached; zero mantissa never fires
  assign first_hit = lf.lf_tick && (wake_period_mantissa != 16'h0000)
                     && (next_window == wake_period_mantissa);

  // advance per low-frequency tick; restart gives the interval
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sleep_cnt <= 31'h0000_0000;
    end else if (sw_reset) begin
      // software clear wins over a tick
      sleep_cnt <= 31'h0000_0000;
    end else if (first_hit) begin
      sleep_cnt <= 31'h0000_0000;
    end else if (lf.lf_tick) begin
      sleep_cnt <= next_cnt;
    end
  end

  // ****************************************
  // first and second events
  // ****************************************
  logic ev1_armed;
  logic [5:0] ev1_left;
  logic second_hit;

  // a new first event while one is still armed flushes the old second event
  // at once, so pairs never merge or vanish
  assign second_hit = ev1_armed
                      && ((lf.lf_tick && (ev1_left == 6'h01)) || first_hit);

  // arm once per first event; load the coded delay
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ev1_armed <= 1'b0;
      ev1_left <= 6'h00;
    end else if (first_hit) begin
      ev1_armed <= 1'b1;
      ev1_left <= swt_pkg::swt_delay_cycles(delay_code);
    end else if (second_hit) begin
      ev1_armed <= 1'b0;
      ev1_left <= 6'h00;
    end else if (ev1_armed && lf.lf_tick) begin
      ev1_left <= ev1_left - 6'h01;
    end
  end

  // event pulses and wake requests, registered
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      first_event_o <= 1'b0;
      second_event_o <= 1'b0;
      vreg_on_o <= 1'b0;
      xosc_start_o <= 1'b0;
    end else begin
      first_event_o <= first_hit;
      second_event_o <= second_hit;
      // wake only from light or deep sleep
      vreg_on_o <= first_hit && pm_sleep;
      xosc_start_o <= first_hit && pm_sleep;
    end
  end

  // ****************************************
  // interrupt control
  // ****************************************
  logic first_event_irq_mask;
  logic second_event_irq_mask;
  logic first_event_pending;
  logic second_event_pending;

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      first_event_irq_mask <= 1'b0;
      second_event_irq_mask <= 1'b0;
    end else if (wr_irq) begin
      first_event_irq_mask <= sfr_wdata_i[swt_pkg::SWT_IRQ_MASK0_BIT];
      second_event_irq_mask <= sfr_wdata_i[swt_pkg::SWT_IRQ_MASK1_BIT];
    end
  end

  // set regardless of mask; write zero clears, set wins
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      first_event_pending <= 1'b0;
      second_event_pending <= 1'b0;
    end else begin
      if (first_hit) begin
        first_event_pending <= 1'b1;
      end else if (wr_irq && !sfr_wdata_i[swt_pkg::SWT_IRQ_FLAG0_BIT]) begin
        first_event_pending <= 1'b0;
      end
      if (second_hit) begin
        second_event_pending <= 1'b1;
      end else if (wr_irq && !sfr_wdata_i[swt_pkg::SWT_IRQ_FLAG1_BIT]) begin
        second_event_pending <= 1'b0;
      end
    end
  end

  // one request from either masked source
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sleep_timer_irq_o <= 1'b0;
    end else begin
      sleep_timer_irq_o <= (first_hit || first_event_pending) && first_event_irq_mask
                           || (second_hit || second_event_pending) && second_event_irq_mask;
    end
  end

  // ****************************************
  // rc calibration
  // ****************************************
  logic [swt_pkg::SWT_CAL_W-1:0] cal_cnt;
  logic cal_seen;
  logic cal_on;

  // only in active mode with the crystal running
  assign cal_on = (pmode == swt_pkg::SWT_PM_ACTIVE) && xosc_running_i;

  // period measure in system clocks, saturating
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cal_cnt <= '0;
      cal_seen <= 1'b0;
    end else if (!cal_on) begin
      // first period after resuming is partial, so discard it
      cal_cnt <= '0;
      cal_seen <= 1'b0;
    end else if (lf.rc_edge) begin
      cal_cnt <= '0;
      cal_seen <= 1'b1;
    end else if (cal_cnt != '1) begin
      cal_cnt <= cal_cnt + 1'b1;
    end
  end

  // steer trim toward crystal over 750; hold last result
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rc_trim_o <= swt_pkg::SWT_RST_TRIM;
    end else if (cal_on && cal_seen && lf.rc_edge) begin
      if ((int'(cal_cnt) > swt_pkg::SWT_CAL_TARGET + swt_pkg::SWT_CAL_TOL)
          && (rc_trim_o != 6'h3f)) begin
        rc_trim_o <= rc_trim_o + 6'h01;
      end else if ((int'(cal_cnt) < swt_pkg::SWT_CAL_TARGET - swt_pkg::SWT_CAL_TOL)
                   && (rc_trim_o != 6'h00)) begin
        rc_trim_o <= rc_trim_o - 6'h01;
      end
    end
  end

  // ****************************************
  // read port
  // ****************************************
  logic [7:0] next_rdata;

  // window bytes; reset bit reads zero; reserved bits zero
  always_comb begin
    next_rdata = 8'h00;
    case (sfr_addr_i)
      swt_pkg::SWT_ADDR_IRQ: begin
        next_rdata = {2'h0, second_event_irq_mask, first_event_irq_mask,
                      2'h0, second_event_pending, first_event_pending};
      end
      swt_pkg::SWT_ADDR_CTL: begin
        next_rdata = {1'b0, delay_code, 2'h0, count_resolution_sel};
      end
      swt_pkg::SWT_ADDR_PER_LO: next_rdata = wake_period_mantissa[7:0];
      swt_pkg::SWT_ADDR_PER_HI: next_rdata = wake_period_mantissa[15:8];
      swt_pkg::SWT_ADDR_CNT_LO: next_rdata = window[7:0];
      swt_pkg::SWT_ADDR_CNT_HI: next_rdata = window[15:8];
      default: next_rdata = 8'h00;
    endcase
  end

  // read data held until the next read
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sfr_rdata_o <= 8'h00;
    end else if (sfr_rd_i) begin
      sfr_rdata_o <= next_rdata;
    end
  end

endmodule
`default_nettype wire

// *** include/swt_pkg.sv ***
// Overview of operation
// - a 31-bit sleep counter advances on every low-frequency clock cycle
// - low-frequency clock comes from the crystal or the low-power rc oscillator
// - counter runs in every power mode except the oscillators-off mode
// - writing one to the reset bit clears the counter; reads return zero
// - first event in light or deep sleep starts regulator and crystal
// - every first event is followed by exactly one second event
// - delay code 000..111 selects 4,6,8,12,16,24,32,48 low-frequency cycles
// - first-event interval is mantissa times two to five times resolution
// - mantissa sits in high and low byte registers, reset 0x87 and 0x6b
// - resolution code picks counter bits 15:0, 20:5, 25:10 or 30:15
// - changing resolution leaves the 31-bit counter untouched
// - two read-only bytes return the selected 16-bit count window
// - rc oscillator calibrates in active mode with crystal on, else holds
// - calibration locks the rc frequency to crystal frequency over 750
// - one interrupt from either event, each source with its own mask
// - pending flags set on their event whatever the mask says
// - irq control holds second mask at bit 5, first mask at bit 4
// - pending flags at bits 1 and 0, cleared only by writing zero
package swt_pkg;

  // ****************************************
  // register map
  // ****************************************
  localparam logic [7:0] SWT_ADDR_IRQ = 8'h00a1;
  localparam logic [7:0] SWT_ADDR_CTL = 8'h00a2;
  localparam logic [7:0] SWT_ADDR_PER_LO = 8'h00a3;
  localparam logic [7:0] SWT_ADDR_PER_HI = 8'h00a4;
  localparam logic [7:0] SWT_ADDR_CNT_LO = 8'h00a5;
  localparam logic [7:0] SWT_ADDR_CNT_HI = 8'h00a6;

  // ****************************************
  // field positions and reset values
  // ****************************************
  localparam int SWT_CTL_DELAY_LSB = 4;
  localparam int SWT_CTL_RESET_BIT = 2;
  localparam int SWT_IRQ_MASK1_BIT = 5;
  localparam int SWT_IRQ_MASK0_BIT = 4;
  localparam int SWT_IRQ_FLAG1_BIT = 1;
  localparam int SWT_IRQ_FLAG0_BIT = 0;
  localparam logic [7:0] SWT_RST_PER_LO = 8'h006b;
  localparam logic [7:0] SWT_RST_PER_HI = 8'h0087;
  localparam logic [2:0] SWT_RST_DELAY = 3'h7;
  localparam logic [1:0] SWT_RST_RES = 2'h0;
  localparam int SWT_CNT_W = 31;
  localparam int SWT_RES_SHIFT = 5;

  // ****************************************
  // timing: rc calibration target
  // ****************************************
  localparam longint SWT_CLK_HZ = 40000000;
  localparam longint SWT_XOSC_HZ = 26000000;
  localparam longint SWT_CAL_DIV = 750;
  // system clocks in one ideal rc period (crystal / 750)
  localparam int SWT_CAL_TARGET = int'((SWT_CAL_DIV * SWT_CLK_HZ) / SWT_XOSC_HZ);
  localparam int SWT_CAL_TOL = 2;
  localparam int SWT_CAL_W = 12;
  localparam logic [5:0] SWT_RST_TRIM = 6'h20;

  typedef enum logic [1:0] {
    SWT_PM_ACTIVE,
    SWT_PM_LIGHT,
    SWT_PM_DEEP,
    SWT_PM_OFF
  } swt_pmode_t;

  // second-event delay in low-frequency cycles
  function automatic logic [5:0] swt_delay_cycles(input logic [2:0] code);
    logic [5:0] d;
    d = 6'h04;
    case (code)
      3'h0: d = 6'h04;
      3'h1: d = 6'h06;
      3'h2: d = 6'h08;
      3'h3: d = 6'h0c;
      3'h4: d = 6'h10;
      3'h5: d = 6'h18;
      3'h6: d = 6'h20;
      default: d = 6'h30;
    endcase
    return d;
  endfunction

endpackage

// *** include/swt_lf_if.sv ***
`timescale 1ns/10ps
`default_nettype none
// low-frequency tick path between edge finder and timer core
interface swt_lf_if;
  logic lf_tick;
  logic rc_edge;
  logic use_rc;
  logic run;
  modport src (output lf_tick, output rc_edge, input use_rc, input run);
  modport snk (input lf_tick, input rc_edge, output use_rc, output run);
endinterface
`default_nettype wire

// *** core/swt_lf_tick.sv ***
`timescale 1ns/10ps
`default_nettype none
module swt_lf_tick (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic xosc32_clk_i,
  input wire logic rcosc_clk_i,
  swt_lf_if.src lf
);

  // ****************************************
  // pin synchronisers
  // ****************************************
  logic [1:0] xo_sync;
  logic [1:0] rc_sync;
  logic xo_prev;
  logic rc_prev;

  // two flops per pin; only the second stage is looked at
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      xo_sync <= 2'h0;
      rc_sync <= 2'h0;
    end else begin
      xo_sync <= {xo_sync[0], xosc32_clk_i};
      rc_sync <= {rc_sync[0], rcosc_clk_i};
    end
  end

  // previous synced level for edge finding
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      xo_prev <= 1'b0;
      rc_prev <= 1'b0;
    end else begin
      xo_prev <= xo_sync[1];
      rc_prev <= rc_sync[1];
    end
  end

  // ****************************************
  // tick select
  // ****************************************
  // source select
  assign lf.rc_edge = rc_sync[1] & ~rc_prev;
  // no tick while oscillators are off
  assign lf.lf_tick = lf.run & (lf.use_rc ? lf.rc_edge : (xo_sync[1] & ~xo_prev));

endmodule
`default_nettype wire

// *** dv/swt_top_monitor.sv ***
`timescale 1ns/10ps
`default_nettype none
module swt_top_monitor (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic [1:0] power_mode_i,
  input wire logic xosc_running_i,
  input wire logic [7:0] sfr_addr_i,
  input wire logic sfr_rd_i,
  input wire logic [7:0] sfr_rdata_o,
  input wire logic first_event_o,
  input wire logic second_event_o,
  input wire logic vreg_on_o,
  input wire logic xosc_start_o,
  input wire logic [5:0] rc_trim_o
);
  // ****************************************
  // event, register and trim checks
  // ****************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);

  a_first_pulse: assert property (first_event_o |=> !first_event_o)
    else $error("first event wider than one cycle");
  // bound covers the 48-tick delay plus sync latency
  a_second_follows: assert property (first_event_o |-> ##[1:900] second_event_o)
    else $error("no second event after first");
  // the wake pulse is registered, so the mode that caused it is one cycle old
  a_vreg_cause: assert property (vreg_on_o |-> first_event_o &&
    $past(power_mode_i) inside {2'h1, 2'h2}) else $error("regulator start without sleep wake");
  a_vreg_sleep: assert property (first_event_o && $stable(power_mode_i) &&
    power_mode_i inside {2'h1, 2'h2} |-> vreg_on_o) else $error("sleep wake missed");
  a_xosc_start: assert property (xosc_start_o == vreg_on_o)
    else $error("crystal start differs from regulator start");
  a_stop_off: assert property ((power_mode_i == 2'h3) [*6] |->
    !first_event_o && !second_event_o) else $error("event with oscillators off");
  a_rdata_hold: assert property (!sfr_rd_i |=> $stable(sfr_rdata_o))
    else $error("read data changed without read");
  a_unmapped_zero: assert property (sfr_rd_i && (sfr_addr_i < 8'ha1 ||
    sfr_addr_i > 8'ha6) |=> sfr_rdata_o == 8'h00) else $error("unmapped read not zero");
  a_reset_bit_zero: assert property (sfr_rd_i && sfr_addr_i == 8'ha2 |=>
    sfr_rdata_o[7] == 1'b0 && sfr_rdata_o[3:2] == 2'h0) else $error("control bits not zero");
  // a few cycles of margin for an rc edge still in the synchroniser
  a_trim_hold: assert property ((power_mode_i != 2'h0 || !xosc_running_i) [*4] |=>
    $stable(rc_trim_o)) else $error("trim moved outside calibration");
  a_trim_step: assert property (!$stable(rc_trim_o) |->
    rc_trim_o == $past(rc_trim_o) + 6'h01 || rc_trim_o == $past(rc_trim_o) - 6'h01)
    else $error("trim jumped");

  c_first: cover property (first_event_o);
  c_second: cover property (second_event_o);
  c_wake: cover property (vreg_on_o);
endmodule
bind swt_top swt_top_monitor swt_top_monitor_i (.clk_i, .rstn_i, .power_mode_i,
  .xosc_running_i, .sfr_addr_i, .sfr_rd_i, .sfr_rdata_o, .first_event_o, .second_event_o,
  .vreg_on_o, .xosc_start_o, .rc_trim_o);
`default_nettype wire

// *** dv/swt_pm_model.sv ***
`timescale 1ns/10ps
`default_nettype none
module swt_pm_model #(
  parameter int XH = 200,
  parameter int RH = 128
) (
  input wire logic [1:0] power_mode_i,
  output logic xosc32_clk_o,
  output logic rcosc_clk_o,
  output int xosc_edges_o,
  output int rc_edges_o
);
  // ****************************************
  // low-frequency oscillators
  // ****************************************
  // sped up so a run stays short; still far slower than the synchroniser
  initial begin
    xosc32_clk_o = 1'b0;
    rcosc_clk_o = 1'b0;
    xosc_edges_o = 0;
    rc_edges_o = 0;
  end
  always begin
    #XH;
    if (power_mode_i != 2'h3) xosc32_clk_o = ~xosc32_clk_o;
  end
  always begin
    #RH;
    if (power_mode_i != 2'h3) rcosc_clk_o = ~rcosc_clk_o;
  end
  always @(posedge xosc32_clk_o) xosc_edges_o++;
  always @(posedge rcosc_clk_o) rc_edges_o++;
endmodule
`default_nettype wire

// *** dv/sleep_wakeup_timer_bench.sv ***
`timescale 1ns/10ps
`default_nettype none
module sleep_wakeup_timer_bench;
  logic clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic use_rc_osc_i = 1'b0;
  logic [1:0] power_mode_i = 2'h3;
  logic xosc_running_i = 1'b0;
  logic [7:0] sfr_addr_i = 8'h00;
  logic sfr_wr_i = 1'b0;
  logic [7:0] sfr_wdata_i = 8'h00;
  logic sfr_rd_i = 1'b0;
  logic [7:0] sfr_rdata_o, w, h;
  logic first_event_o, second_event_o, vreg_on_o, xosc_start_o, sleep_timer_irq_o;
  logic [5:0] rc_trim_o, tr;
  logic xosc32_clk, rcosc_clk;
  int xn, rn, t0, t1, r0, r1, i;
  int num_errors = 0;
  int samples_checked = 0;
  int dl[8] = '{4, 6, 8, 12, 16, 24, 32, 48};

  // ****************************************
  // clock, design and partner
  // ****************************************
  always #12.5 clk_i = ~clk_i;
  swt_top swt_top_i (.clk_i, .rstn_i, .xosc32_clk_i(xosc32_clk), .rcosc_clk_i(rcosc_clk),
    .use_rc_osc_i, .power_mode_i, .xosc_running_i, .sfr_addr_i, .sfr_wr_i, .sfr_wdata_i,
    .sfr_rd_i, .sfr_rdata_o, .first_event_o, .second_event_o, .vreg_on_o, .xosc_start_o,
    .sleep_timer_irq_o, .rc_trim_o);
  swt_pm_model swt_pm_model_i (.power_mode_i, .xosc32_clk_o(xosc32_clk),
    .rcosc_clk_o(rcosc_clk), .xosc_edges_o(xn), .rc_edges_o(rn));

  // ****************************************
  // access and compare tasks
  // ****************************************
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string n);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    sfr_addr_i <= a;
    sfr_wdata_i <= d;
    sfr_wr_i <= 1'b1;
    @(posedge clk_i);
    sfr_wr_i <= 1'b0;
  endtask
  // read data lands at the edge sampling the strobe; look half a cycle on
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_i);
    sfr_addr_i <= a;
    sfr_rd_i <= 1'b1;
    @(posedge clk_i);
    sfr_rd_i <= 1'b0;
    @(negedge clk_i);
    d = sfr_rdata_o;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] e, input string n);
    logic [7:0] d;
    rd(a, d);
    chk(d, e, n);
  endtask
  // events are one-cycle pulses, so each is seen at exactly one falling edge
  task automatic wait_ev(input bit sec, output int x, output int r);
    int k;
    k = 0;
    do begin
      @(negedge clk_i);
      k++;
    end while (!(sec ? second_event_o : first_event_o) && k < 5000);
    if (k >= 5000) chk(0, 1, "event wait");
    x = xn;
    r = rn;
  endtask
  task automatic stop_test;
    if (num_errors == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // watchdog well beyond the expected run of about 25k cycles
  initial begin
    repeat (60000) @(posedge clk_i);
    num_errors++;
    stop_test();
  end

  // ****************************************
  // test sequence
  // ****************************************
  initial begin
    repeat (6) @(posedge clk_i);
    rstn_i <= 1'b1;
    // reset values, counter frozen with oscillators off
    rdc(8'ha1, 8'h00, "irq control");
    rdc(8'ha2, 8'h70, "timer control");
    rdc(8'ha3, 8'h6b, "period low");
    rdc(8'ha4, 8'h87, "period high");
    rdc(8'ha6, 8'h00, "count high");
    rdc(8'h50, 8'h00, "unmapped");
    chk(rc_trim_o, 6'h20, "trim reset");
    // every delay code, counter cleared each pass
    @(posedge clk_i) power_mode_i <= 2'h0;
    wr(8'ha4, 8'h00);
    wr(8'ha3, 8'h3c);
    for (i = 0; i < 8; i++) begin
      wr(8'ha2, 8'(i * 16 + 4));
      wait_ev(0, t0, r0);
      chk(vreg_on_o, 1'b0, "no wake in active");
      wait_ev(1, t1, r1);
      chk(t1 - t0, dl[i], "second delay");
      wait_ev(0, t1, r1);
      chk(t1 - t0, 60, "period");
    end
    // resolution 1 scales the mantissa by 32
    wr(8'ha3, 8'h03);
    wr(8'ha2, 8'h75);
    wait_ev(0, t0, r0);
    wait_ev(0, t1, r1);
    chk(t1 - t0, 96, "period res 1");
    // rc oscillator as tick source
    @(posedge clk_i) use_rc_osc_i <= 1'b1;
    wr(8'ha3, 8'h3c);
    wr(8'ha2, 8'h04);
    wait_ev(0, t0, r0);
    wait_ev(0, t1, r1);
    chk(r1 - r0, 60, "rc period");
    @(posedge clk_i) use_rc_osc_i <= 1'b0;
    // masks, pending flags and clearing
    wr(8'ha2, 8'h04);
    wait_ev(0, t0, r0);
    chk(sleep_timer_irq_o, 1'b0, "irq masked");
    wait_ev(1, t0, r0);
    rdc(8'ha1, 8'h03, "flags");
    wr(8'ha1, 8'h13);
    rdc(8'ha1, 8'h13, "mask first");
    chk(sleep_timer_irq_o, 1'b1, "irq first");
    wr(8'ha1, 8'h12);
    rdc(8'ha1, 8'h12, "clear first");
    chk(sleep_timer_irq_o, 1'b0, "irq cleared");
    wr(8'ha1, 8'h22);
    rdc(8'ha1, 8'h22, "mask second");
    chk(sleep_timer_irq_o, 1'b1, "irq second");
    wr(8'ha1, 8'h00);
    // wake from light sleep, then from deep sleep
    @(posedge clk_i) power_mode_i <= 2'h1;
    wait_ev(0, t0, r0);
    chk(vreg_on_o, 1'b1, "wake regulator");
    chk(xosc_start_o, 1'b1, "wake crystal");
    @(posedge clk_i) power_mode_i <= 2'h2;
    wait_ev(0, t0, r0);
    chk(vreg_on_o, 1'b1, "deep wake regulator");
    chk(xosc_start_o, 1'b1, "deep wake crystal");
    // trim moves in active mode, then holds in sleep with the crystal still on
    tr = rc_trim_o;
    @(posedge clk_i) xosc_running_i <= 1'b1;
    power_mode_i <= 2'h0;
    repeat (300) @(posedge clk_i);
    @(negedge clk_i);
    chk(rc_trim_o < tr, 1'b1, "trim pulled down");
    @(posedge clk_i) power_mode_i <= 2'h1;
    @(negedge clk_i) tr = rc_trim_o;
    repeat (300) @(posedge clk_i);
    @(negedge clk_i);
    chk(rc_trim_o, tr, "trim held");
    @(posedge clk_i) xosc_running_i <= 1'b0;
    power_mode_i <= 2'h0;
    // window selection over a frozen count
    wr(8'ha3, 8'h00);
    wr(8'ha2, 8'h74);
    repeat (1000) @(posedge clk_i);
    power_mode_i <= 2'h3;
    repeat (20) @(posedge clk_i);
    rd(8'ha5, w);
    rd(8'ha6, h);
    chk(w > 8'h20, 1'b1, "count ran");
    wr(8'ha2, 8'h71);
    rdc(8'ha5, 8'({h, w} >> 5), "window res 1");
    wr(8'ha2, 8'h72);
    rdc(8'ha5, 8'({h, w} >> 10), "window res 2");
    wr(8'ha2, 8'h73);
    rdc(8'ha5, 8'({h, w} >> 15), "window res 3");
    wr(8'ha5, 8'hff);
    wr(8'ha2, 8'h70);
    repeat (300) @(posedge clk_i);
    rdc(8'ha5, w, "count kept");
    wr(8'ha2, 8'h74);
    rdc(8'ha5, 8'h00, "count cleared");
    rdc(8'ha2, 8'h70, "reset bit");
    stop_test();
  end
endmodule
`default_nettype wire
